// [hdl/pslc_pkg.sv]
// Shared types and constants for the synthesizer configuration latch block.
// Assumes a single main clock domain plus a serial link clock at the top level.
package pslc_pkg;

    // ********************************************************
    // Latch addressing (two select bits at the bottom of a word)
    // ********************************************************
    localparam int WORD_BITS = 24;
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_REFERENCE = 2'h1;
    localparam logic [1:0] SEL_FEEDBACK = 2'h2;
    localparam logic [1:0] SEL_TEST = 2'h3;

    // ********************************************************
    // Values after reset and counts
    // ********************************************************
    localparam logic [23:0] LATCH_RESET = 24'h000000;
    localparam logic [2:0] LOCK_CYCLES_FINE = 3'h5;
    localparam logic [2:0] LOCK_CYCLES_COARSE = 3'h3;
    localparam logic [1:0] SYNC_PD_EDGES = 2'h2;
    localparam logic [12:0] MAIN_COUNT_MIN = 13'h0003;
    localparam logic [5:0] PRESC_MOD_A = 6'h08;
    localparam logic [5:0] PRESC_MOD_B = 6'h10;
    localparam logic [5:0] PRESC_MOD_C = 6'h20;

    // ********************************************************
    // Latch layouts, most significant field first
    // ********************************************************
    typedef struct packed {
        logic [1:0] prescaler;
        logic powerdown_sync_select;
        logic powerdown_request_bit;
        logic [2:0] pump_current_two;
        logic [2:0] pump_current_one;
        logic [1:0] output_level;
        logic mute_until_lock;
        logic pump_gain_select;
        logic pump_tristate;
        logic detector_polarity;
        logic [2:0] mux_select;
        logic counter_clear_bit;
        logic [1:0] core_current;
        logic [1:0] latch_select;
    } pslc_control_t;

    typedef struct packed {
        logic prescaler_source_select;
        logic output_halver_enable;
        logic pump_gain_select;
        logic [12:0] main_count;
        logic spare_bit;
        logic [4:0] swallow_count;
        logic [1:0] latch_select;
    } pslc_feedback_t;

    typedef struct packed {
        logic [1:0] spare_bits;
        logic [1:0] band_clock_divider;
        logic factory_test_bit;
        logic lock_precision_bit;
        logic [1:0] antibacklash_width;
        logic [13:0] ref_divide;
        logic [1:0] latch_select;
    } pslc_reference_t;

    // Settings presented to the analog side
    typedef struct packed {
        logic powered_down;
        logic counters_held;
        logic pump_tristate;
        logic [2:0] pump_current;
        logic detector_positive;
        logic rf_enable;
        logic ref_buffer_enable;
        logic lock_detect;
        logic output_halve;
        logic prescaler_from_halver;
        logic [18:0] feedback_ratio;
        logic main_count_legal;
        logic [1:0] output_level;
        logic [1:0] core_current;
        logic [2:0] mux_select;
        logic [1:0] antibacklash_width;
    } pslc_out_t;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SYNC_WAIT,
        PWR_DOWN
    } pslc_pwr_t;

endpackage

// [hdl/pslc_top.sv]
// Configuration latches, power-down sequencing and divider control.
// Assumes the host stops the serial clock and holds data steady while the
// latch strobe is high, so the shift register is quiet when it is copied.
//
// Function
// RULE_01 - Request bit with sync select 0 powers down right after latching.
// RULE_02 - Request and sync select both 1: power down on second reference pulse.
// RULE_03 - Chip enable low disables the device regardless of programmed bits.
// RULE_04 - Power-down holds counters, tristates pump, clears lock, mutes RF, stops buffer.
// RULE_05 - Serial shift register keeps working during power-down.
// RULE_06 - Two three-bit pump current settings come from the control latch.
// RULE_07 - Mute-until-lock keeps RF outputs off until lock is reported.
// RULE_08 - Control gain bit picks current setting two when 1, one when 0.
// RULE_09 - Gain bit also in feedback latch; latest write from either wins.
// RULE_10 - Pump tristate bit at 1 forces the charge pump to three-state.
// RULE_11 - Detector polarity bit 1 selects positive, 0 negative.
// RULE_12 - Counter clear bit holds reference and feedback counters in reset.
// RULE_13 - Select (1,0) loads feedback latch; (0,1) loads reference latch.
// RULE_14 - Feedback latch holds a five-bit swallow count, 0 through 31.
// RULE_15 - Feedback latch holds a thirteen-bit main count, legal 3 through 8191.
// RULE_16 - Feedback ratio is prescaler modulus times main count plus swallow count.
// RULE_17 - Halver enable bit selects output divide-by-two.
// RULE_18 - Prescaler source bit feeds halved signal to prescaler when 1.
// RULE_19 - Reference latch holds a fourteen-bit ratio, legal 1 through 16383.
// RULE_20 - Precision bit 1 needs five good reference cycles for lock, else three.
// RULE_21 - Test bit 0: test latch ignored; host keeps it 0.
// RULE_22 - Band logic clocked by reference output through optional divider.
// RULE_23 - Select (0,0) loads the control latch.
// RULE_24 - Host shifts 24 bits on rising serial clock; strobe high transfers them.
// RULE_25 - Host loads reference, then control, then feedback latch after power-up.
`timescale 1ns/1ps
`default_nettype none

module pslc_top
    import pslc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic latch_strobe,
    input wire logic chip_enable,
    input wire logic ref_in,
    input wire logic phase_ok,
    output pslc_out_t settings,
    output logic band_clock_pulse
);

    // ********************************************************
    // Helpers
    // ********************************************************
    function automatic logic [5:0] presc_modulus(input logic [1:0] code);
        case (code)
            2'h0: presc_modulus = PRESC_MOD_A;
            2'h1: presc_modulus = PRESC_MOD_B;
            default: presc_modulus = PRESC_MOD_C;
        endcase
    endfunction

    function automatic logic [18:0] feed_ratio(input logic [5:0] p, input logic [12:0] b,
                                              input logic [4:0] a);
        logic [18:0] prod;
        prod = 19'(p) * 19'(b);
        feed_ratio = prod + 19'(a);
    endfunction

    // ********************************************************
    // Serial link domain
    // ********************************************************
    // No reset here: the link clock may be stopped, and the word is only
    // used after a full frame has been clocked in.
    logic [23:0] shift_q;

    always_ff @(posedge serial_clock) begin
        shift_q <= {shift_q[22:0], serial_data}; // RULE_24 RULE_05
    end

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    logic [2:0] strobe_sync_q;
    logic [1:0] ce_sync_q;
    logic [2:0] ref_sync_q;
    logic [1:0] phase_sync_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            strobe_sync_q <= 3'h0;
            ce_sync_q <= 2'h0;
            ref_sync_q <= 3'h0;
            phase_sync_q <= 2'h0;
        end else begin
            strobe_sync_q <= {strobe_sync_q[1:0], latch_strobe};
            ce_sync_q <= {ce_sync_q[0], chip_enable};
            ref_sync_q <= {ref_sync_q[1:0], ref_in};
            phase_sync_q <= {phase_sync_q[0], phase_ok};
        end
    end

    logic ce_s;
    logic latch_event;
    logic ref_rise;
    logic [23:0] word;

    assign ce_s = ce_sync_q[1];
    assign latch_event = strobe_sync_q[1] & ~strobe_sync_q[2];
    assign ref_rise = ref_sync_q[1] & ~ref_sync_q[2];
    // Quasi-static crossing: the strobe edge qualifies a word that is stable
    assign word = shift_q;

    // ********************************************************
    // Latches
    // ********************************************************
    pslc_control_t ctrl_q;
    pslc_feedback_t feed_q;
    pslc_reference_t ref_q;
    logic ctrl_seen_q;
    logic gain_q;
    logic ctrl_write;
    logic feed_write;
    logic ref_write;

    assign ctrl_write = latch_event && (word[1:0] == SEL_CONTROL);
    assign feed_write = latch_event && (word[1:0] == SEL_FEEDBACK);
    assign ref_write = latch_event && (word[1:0] == SEL_REFERENCE);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_q <= pslc_control_t'(LATCH_RESET);
            feed_q <= pslc_feedback_t'(LATCH_RESET);
            ref_q <= pslc_reference_t'(LATCH_RESET);
            ctrl_seen_q <= 1'b0;
        end else begin
            if (ctrl_write) begin
                ctrl_q <= pslc_control_t'(word); // RULE_23 RULE_06
                ctrl_seen_q <= 1'b1;
            end
            if (feed_write) begin
                feed_q <= pslc_feedback_t'(word); // RULE_13 RULE_14 RULE_15
            end
            if (ref_write) begin
                ref_q <= pslc_reference_t'(word); // RULE_13 RULE_19 RULE_21
            end
            // Test latch words are dropped: normal operation only
        end
    end

    // One gain bit shared by two latches
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            gain_q <= 1'b0;
        end else if (ctrl_write) begin
            gain_q <= word[10]; // RULE_09
        end else if (feed_write) begin
            gain_q <= word[21]; // RULE_09
        end
    end

    // ********************************************************
    // Power-down sequencing
    // ********************************************************
    pslc_pwr_t pwr_q;
    logic [1:0] sync_edges_q;
    logic powered_down;
    logic counters_hold;
    logic ref_pulse;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pwr_q <= PWR_RUN;
            sync_edges_q <= 2'h0;
        end else if (ctrl_write) begin
            sync_edges_q <= 2'h0;
            if (!word[20]) begin
                pwr_q <= PWR_RUN;
            end else if (!word[21]) begin
                pwr_q <= PWR_DOWN; // RULE_01
            end else if (pwr_q == PWR_DOWN) begin
                pwr_q <= PWR_DOWN;
            end else begin
                pwr_q <= PWR_SYNC_WAIT; // RULE_02
            end
        end else begin
            case (pwr_q)
                PWR_SYNC_WAIT: begin
                    if (ref_pulse) begin
                        if (sync_edges_q == SYNC_PD_EDGES - 2'h1) begin
                            pwr_q <= PWR_DOWN; // RULE_02
                        end
                        sync_edges_q <= sync_edges_q + 2'h1;
                    end
                end
                PWR_RUN: sync_edges_q <= 2'h0;
                PWR_DOWN: sync_edges_q <= 2'h0;
                default: pwr_q <= PWR_RUN;
            endcase
        end
    end

    // Until the first control word the part stays powered down
    assign powered_down = !ce_s || !ctrl_seen_q || (pwr_q == PWR_DOWN); // RULE_03 RULE_04
    assign counters_hold = powered_down || ctrl_q.counter_clear_bit; // RULE_12 RULE_04

    // ********************************************************
    // Reference counter and band select clock
    // ********************************************************
    logic [13:0] ref_cnt_q;
    logic [13:0] ref_ratio;
    logic [7:0] band_cnt_q;
    logic [7:0] band_div;

    // A zero ratio is outside the legal range; treat it as one
    assign ref_ratio = (ref_q.ref_divide == 14'h0000) ? 14'h0001 : ref_q.ref_divide;
    // Compare with >= so a ratio lowered mid-count cannot send the count round the wrap
    assign ref_pulse = ref_rise && (ref_cnt_q >= ref_ratio - 14'h0001) && !counters_hold;
    assign band_div = 8'h01 << ref_q.band_clock_divider;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ref_cnt_q <= 14'h0000;
        end else if (counters_hold) begin
            ref_cnt_q <= 14'h0000; // RULE_04 RULE_12
        end else if (ref_rise) begin
            ref_cnt_q <= ref_pulse ? 14'h0000 : ref_cnt_q + 14'h0001; // RULE_19
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            band_cnt_q <= 8'h00;
            band_clock_pulse <= 1'b0;
        end else if (counters_hold) begin
            band_cnt_q <= 8'h00;
            band_clock_pulse <= 1'b0;
        end else if (ref_pulse) begin
            // Same wrap hazard as the reference count when the divider is lowered
            band_cnt_q <= (band_cnt_q >= band_div - 8'h01) ? 8'h00 : band_cnt_q + 8'h01;
            band_clock_pulse <= (band_cnt_q >= band_div - 8'h01); // RULE_22
        end else begin
            band_clock_pulse <= 1'b0;
        end
    end

    // ********************************************************
    // Digital lock detect
    // ********************************************************
    logic [2:0] good_cnt_q;
    logic locked_q;
    logic [2:0] lock_need;

    assign lock_need = ref_q.lock_precision_bit ? LOCK_CYCLES_FINE : LOCK_CYCLES_COARSE;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            good_cnt_q <= 3'h0;
            locked_q <= 1'b0;
        end else if (powered_down) begin
            good_cnt_q <= 3'h0; // RULE_04
            locked_q <= 1'b0;
        end else if (ref_pulse) begin
            if (!phase_sync_q[1]) begin
                good_cnt_q <= 3'h0;
                locked_q <= 1'b0;
            end else if (good_cnt_q < lock_need) begin
                good_cnt_q <= good_cnt_q + 3'h1;
                if (good_cnt_q == lock_need - 3'h1) begin
                    locked_q <= 1'b1; // RULE_20
                end
            end
        end
    end

    // ********************************************************
    // Settings register
    // ********************************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            settings <= '0;
            settings.powered_down <= 1'b1;
            settings.counters_held <= 1'b1;
            settings.pump_tristate <= 1'b1;
        end else begin
            settings.powered_down <= powered_down;
            settings.counters_held <= counters_hold;
            settings.pump_tristate <= powered_down || ctrl_q.pump_tristate; // RULE_10
            settings.pump_current <= gain_q ? ctrl_q.pump_current_two
                                            : ctrl_q.pump_current_one; // RULE_08 RULE_06
            settings.detector_positive <= ctrl_q.detector_polarity; // RULE_11
            settings.rf_enable <= !powered_down
                                  && (!ctrl_q.mute_until_lock || locked_q); // RULE_07
            settings.ref_buffer_enable <= !powered_down;
            // Gated here too, so the flag drops in the same cycle as the outputs
            settings.lock_detect <= locked_q && !powered_down; // RULE_04
            settings.output_halve <= feed_q.output_halver_enable; // RULE_17
            settings.prescaler_from_halver <= feed_q.prescaler_source_select; // RULE_18
            settings.feedback_ratio <= feed_ratio(presc_modulus(ctrl_q.prescaler),
                                                  feed_q.main_count,
                                                  feed_q.swallow_count); // RULE_16
            settings.main_count_legal <= feed_q.main_count >= MAIN_COUNT_MIN; // RULE_15
            settings.output_level <= ctrl_q.output_level;
            settings.core_current <= ctrl_q.core_current;
            settings.mux_select <= ctrl_q.mux_select;
            settings.antibacklash_width <= ref_q.antibacklash_width;
        end
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_async_pd_entry: assert property (ctrl_write && word[20] && !word[21]
        |=> pwr_q == PWR_DOWN) // RULE_01
        else $error("asynchronous power-down not entered");
    a_sync_pd_wait: assert property (ctrl_write && word[20] && word[21] && pwr_q == PWR_RUN
        |=> pwr_q == PWR_SYNC_WAIT) // RULE_02
        else $error("synchronous power-down did not wait");
    a_sync_pd_second: assert property (pwr_q == PWR_SYNC_WAIT && sync_edges_q == 2'h1
        && ref_pulse && !ctrl_write |=> pwr_q == PWR_DOWN) // RULE_02
        else $error("second reference pulse did not power down");
    a_sync_pd_first: assert property (pwr_q == PWR_SYNC_WAIT && sync_edges_q == 2'h0
        && ref_pulse && !ctrl_write |=> pwr_q == PWR_SYNC_WAIT) // RULE_02
        else $error("powered down on first reference pulse");
    a_ce_disable: assert property (!ce_s |=> settings.powered_down) // RULE_03
        else $error("chip enable low did not disable");
    a_pd_effects: assert property (settings.powered_down |-> settings.pump_tristate
        && !settings.rf_enable && !settings.ref_buffer_enable
        && !settings.lock_detect && settings.counters_held) // RULE_04
        else $error("power-down effects missing");
    a_mute_lock: assert property (settings.rf_enable && ctrl_q.mute_until_lock
        && $stable(ctrl_q) |-> settings.lock_detect) // RULE_07
        else $error("RF enabled before lock");
    a_gain_latest: assert property (feed_write && !ctrl_write
        |=> gain_q == $past(word[21])) // RULE_09
        else $error("feedback gain write lost");
    a_pump_select: assert property (1'b1 |=> settings.pump_current
        == ($past(gain_q) ? $past(ctrl_q.pump_current_two)
                          : $past(ctrl_q.pump_current_one))) // RULE_08
        else $error("wrong pump current setting");
    a_route_feed: assert property (feed_write |=> feed_q == $past(word)) // RULE_13
        else $error("feedback word not routed");
    a_clear_holds: assert property (ctrl_q.counter_clear_bit
        |=> ref_cnt_q == 14'h0000) // RULE_12
        else $error("counter clear did not hold counter");
    a_lock_needs: assert property ($rose(locked_q) |-> $past(good_cnt_q)
        == $past(lock_need) - 3'h1) // RULE_20
        else $error("lock declared with wrong count");
    a_route_ctrl: assert property (ctrl_write |=> ctrl_q == $past(word)) // RULE_23
        else $error("control word not routed");
    a_route_ref: assert property (ref_write |=> ref_q == $past(word)) // RULE_13
        else $error("reference word not routed");
    a_test_ignored: assert property (latch_event && word[1:0] == SEL_TEST
        |=> $stable(ctrl_q) && $stable(feed_q) && $stable(ref_q) && $stable(gain_q)) // RULE_21
        else $error("test latch word changed a latch");
    a_pd_lock_clear: assert property (powered_down |=> !locked_q && !settings.lock_detect) // RULE_04
        else $error("lock detect not reset by power-down");
    a_band_tick: assert property (ref_pulse && band_div == 8'h01 |=> band_clock_pulse) // RULE_22
        else $error("undivided band clock tick missing");
    a_band_source: assert property (band_clock_pulse |-> $past(ref_pulse)) // RULE_22
        else $error("band clock tick without reference pulse");
    a_gain_ctrl: assert property (ctrl_write |=> gain_q == $past(word[10])) // RULE_09
        else $error("control gain write lost");

    c_async_pd: cover property (ctrl_write && word[20] && !word[21] ##1 pwr_q == PWR_DOWN);
    c_sync_pd: cover property (pwr_q == PWR_SYNC_WAIT ##1 pwr_q == PWR_DOWN);
    c_lock: cover property ($rose(locked_q));
    c_ce_low: cover property (ctrl_seen_q && $fell(ce_s));
    c_test_word: cover property (latch_event && word[1:0] == SEL_TEST);

endmodule

`default_nettype wire

// [sim/pll_synth_latch_config_tb.sv]
// Self-checking bench for the latch block against an integer model of the latches.
// Assumes the host model drives the link and the bench drives the other pins.
`timescale 1ns/1ps
`default_nettype none

module pll_synth_latch_config_tb import pslc_pkg::*;;
    logic clock, rst_n, chip_enable, ref_in, phase_ok;
    logic serial_clock, serial_data, latch_strobe, band_clock_pulse;
    pslc_out_t settings;
    logic [23:0] m_ctl, m_fbk, m_ref, ctl_run;
    logic m_gain, m_down, m_lock;
    int num_errors = 0;
    int cmp_count = 0;
    int band_count = 0;
    int n0;

    pslc_host_model host (.clock(clock), .serial_clock(serial_clock),
        .serial_data(serial_data), .latch_strobe(latch_strobe));
    pslc_top uut (.clock(clock), .rst_n(rst_n), .serial_clock(serial_clock),
        .serial_data(serial_data), .latch_strobe(latch_strobe), .chip_enable(chip_enable),
        .ref_in(ref_in), .phase_ok(phase_ok), .settings(settings),
        .band_clock_pulse(band_clock_pulse));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        if (band_clock_pulse === 1'b1) band_count <= band_count + 1;
    end

    // ****************************************
    // Comparison and model
    // ****************************************
    task automatic stop_test();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic check_settings();
        pslc_out_t e;
        int pres;
        pres = (m_ctl[23:22] == 2'h0) ? 8 : (m_ctl[23:22] == 2'h1) ? 16 : 32;
        e = '0;
        e.powered_down = m_down;
        e.counters_held = m_down | m_ctl[4];
        e.pump_tristate = m_down | m_ctl[9];
        e.pump_current = m_gain ? m_ctl[19:17] : m_ctl[16:14];
        e.detector_positive = m_ctl[8];
        e.rf_enable = !m_down && (!m_ctl[11] || m_lock);
        e.ref_buffer_enable = !m_down;
        e.lock_detect = m_lock;
        e.output_halve = m_fbk[22];
        e.prescaler_from_halver = m_fbk[23];
        e.feedback_ratio = 19'(pres * int'(m_fbk[20:8]) + int'(m_fbk[6:2]));
        e.main_count_legal = m_fbk[20:8] >= MAIN_COUNT_MIN;
        e.output_level = m_ctl[13:12];
        e.core_current = m_ctl[3:2];
        e.mux_select = m_ctl[7:5];
        e.antibacklash_width = m_ref[17:16];
        chk("settings", 64'(settings), 64'(e));
    endtask

    task automatic send(input logic [23:0] w);
        host.send_word(w);
        if (w[1:0] == SEL_CONTROL) begin
            m_ctl = w;
            m_gain = w[10];
            if (!w[20]) m_down = 1'b0;
            else if (!w[21]) m_down = 1'b1;
        end
        if (w[1:0] == SEL_FEEDBACK) begin
            m_fbk = w;
            m_gain = w[21];
        end
        if (w[1:0] == SEL_REFERENCE) m_ref = w;
        if (m_down) m_lock = 1'b0;
        check_settings();
    endtask

    task automatic ref_pulses(input int n);
        repeat (n * int'(m_ref[15:2])) begin
            ref_in = 1'b1;
            repeat (3) @(negedge clock);
            ref_in = 1'b0;
            repeat (3) @(negedge clock);
        end
        repeat (8) @(negedge clock);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        #500000;
        num_errors++;
        stop_test();
    end

    initial begin
        void'($urandom(32'h70F2));
        {rst_n, ref_in, phase_ok, chip_enable} = 4'h1;
        {m_ctl, m_fbk, m_ref, m_gain, m_down, m_lock} = {72'h0, 3'h2};
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        check_settings();
        // Reference first, then control, then feedback, test bit kept clear
        send({6'h00, 2'h2, 14'h0002, SEL_REFERENCE});
        send({10'h0A7, 2'h2, 4'h1, 3'h5, 3'h1, SEL_CONTROL});
        send({3'h3, 13'(3 + $urandom % 8189), 1'b0, 5'($urandom % 32), SEL_FEEDBACK});
        for (int k = 0; k < 4; k++) begin
            send({2'(k), 2'h0, 3'(k + 1), 3'(6 - k), 2'(k), 1'b0, k[0], k[1], ~k[0], 3'(k),
                1'b0, 2'(k), SEL_CONTROL});
        end
        send({3'h4, 13'h1FFF, 1'b0, 5'h1F, SEL_FEEDBACK});
        send({3'h3, 13'h0002, 1'b0, 5'h00, SEL_FEEDBACK});
        send({22'($urandom), SEL_TEST});
        send(m_ctl | 24'h000010);
        ctl_run = {10'h0A2, 2'h1, 4'h9, 3'h1, 3'h3, SEL_CONTROL};
        send(ctl_run);
        // Lock with coarse precision, outputs muted until then
        phase_ok = 1'b1;
        ref_pulses(2);
        check_settings();
        ref_pulses(1);
        m_lock = 1'b1;
        check_settings();
        chk("band_count", 64'(band_count), 64'd3);
        // Gated power-down waits for the second reference pulse
        send(ctl_run | 24'h300000);
        ref_pulses(1);
        check_settings();
        ref_pulses(1);
        {m_down, m_lock} = 2'b10;
        check_settings();
        send({3'h1, 13'(3 + $urandom % 8189), 1'b0, 5'($urandom % 32), SEL_FEEDBACK});
        send(ctl_run);
        send(ctl_run | 24'h100000);
        send(ctl_run);
        chip_enable = 1'b0;
        repeat (6) @(negedge clock);
        m_down = 1'b1;
        check_settings();
        chip_enable = 1'b1;
        repeat (6) @(negedge clock);
        m_down = 1'b0;
        check_settings();
        // Fine precision needs five good reference cycles
        send({6'h01, 2'h1, 14'h0002, SEL_REFERENCE});
        n0 = band_count;
        ref_pulses(4);
        check_settings();
        ref_pulses(1);
        m_lock = 1'b1;
        check_settings();
        chk("band_pulses", 64'(band_count - n0), 64'd5);
        stop_test();
    end
endmodule

`default_nettype wire

// [sim/pslc_host_model.sv]
// Host side of the three-wire link: shifts 24-bit words and pulses the latch strobe.
// Assumes one caller at a time and the main clock for strobe timing.
`timescale 1ns/1ps
`default_nettype none

module pslc_host_model (
    input wire logic clock,
    output logic serial_clock,
    output logic serial_data,
    output logic latch_strobe
);
    initial begin
        serial_clock = 1'b0;
        serial_data = 1'b1;
        latch_strobe = 1'b0;
    end

    // ****************************************
    // Word transfer, MSB first, 160 ns link period
    // ****************************************
    task automatic send_word(input logic [23:0] w);
        #37;
        for (int i = 23; i >= 0; i--) begin
            serial_data = w[i];
            #80 serial_clock = 1'b1;
            #80 serial_clock = 1'b0;
        end
        // Released line shows the inverse so a stale bit can never pass for data
        serial_data = ~w[0];
        @(negedge clock);
        latch_strobe = 1'b1;
        repeat (8) @(negedge clock);
        latch_strobe = 1'b0;
        repeat (8) @(negedge clock);
    endtask
endmodule

`default_nettype wire
